// file: common/boot_loader_pkg.sv
// shared constants and types for the serial memory boot loader
// Behaviour
// - after reset start reading memory; first returned zero bit means memory attached
// - first 16-bit word all ones means blank memory
// - first 16-bit word all zeros means memory absent
// - blank or absent memory skips loading; registers keep defaults
// - memory-present flag set when memory is programmed or blank
// - absent memory: device applies defaults and sets local-init-status itself
// - blank memory: device applies defaults and sets local-init-status itself
// - until init-status is one, PCI accesses get Retry or are not claimed
// - user pin caught at reset release; low selects no response
// - user pin caught high selects Retry until init-status is one
// - after reset the user pin is readable as a general-purpose input
// - extra-long-load bit clear selects the long load after reset release
// - upper word loads first, then lower word, each shifted MSB first
// - long load reads 34 sequential 16-bit words in register order
// - software reads and writes of the memory move 32 bits each
// - serial memory clock is the core clock divided by 268
// - extra-long-load bit set reads 50 words instead
// - local ready held off while the serial load runs
package boot_loader_pkg;
  localparam int unsigned SK_DIV       = 268;          // core clocks per serial clock
  localparam int unsigned SK_HALF      = SK_DIV / 2;
  localparam int unsigned DIV_W        = 9;
  localparam int unsigned WORD_W       = 16;
  localparam int unsigned LONG_WORDS   = 34;
  localparam int unsigned XLONG_WORDS  = 50;
  localparam int unsigned MEM_ADDR_W   = 8;
  localparam int unsigned CMD_W        = 3 + MEM_ADDR_W; // start, opcode, address
  localparam int unsigned OUT_W        = CMD_W + WORD_W;
  localparam int unsigned OCNT_W       = 5;
  localparam int unsigned ICNT_W       = 10;
  localparam int unsigned XLONG_BIT    = 25;            // of space0_bus_region_desc
  localparam int unsigned PRESENT_BIT  = 28;            // of serial_mem_control_reg
  localparam int unsigned INIT_BIT     = 2;             // of local_misc_control_1
  localparam int unsigned INIT_WORD    = 17;            // image word holding that byte
  localparam int unsigned INIT_WBIT    = 8 + INIT_BIT;  // byte sits in the upper half
  localparam logic [1:0]  OP_READ      = 2'h2;
  localparam logic [1:0]  OP_WRITE     = 2'h1;
  localparam logic [1:0]  OP_EWEN      = 2'h0;
  localparam logic [MEM_ADDR_W-1:0] EWEN_ADDR = 8'hc0;
  localparam logic [WORD_W-1:0] BLANK_WORD  = 16'hffff;
  localparam logic [WORD_W-1:0] ABSENT_WORD = 16'h0000;

  // one loaded configuration register
  typedef struct packed {
    logic [4:0]  index;
    logic [31:0] data;
  } cfg_write_t;

  // software request to the serial memory
  typedef struct packed {
    logic                  write;
    logic [MEM_ADDR_W-1:0] addr;
    logic [31:0]           wdata;
  } sw_req_t;

  // one serial frame to launch
  typedef struct packed {
    logic [OUT_W-1:0]  sr;
    logic [OCNT_W-1:0] ocnt;
    logic [ICNT_W-1:0] icnt;
  } frame_t;
endpackage : boot_loader_pkg

// file: core/serial_eeprom_boot_loader.sv
// serial memory detect, configuration load and PCI init gating
`timescale 1ns/1ps
module serial_eeprom_boot_loader (
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     reset_n,
  // serial memory pins
  output logic                          serial_mem_clock,
  output logic                          serial_mem_select,
  input  wire logic                     serial_mem_data_pin_i,
  output logic                          serial_mem_data_pin_o,
  output logic                          serial_mem_data_pin_oe,
  // user pin
  input  wire logic                     user_input_pin,
  output logic                          user_input_level,
  output logic                          pci_retry_mode,
  // configuration and local processor
  input  wire logic [31:0]              space0_bus_region_desc,
  input  wire logic                     local_init_set,
  output logic                          local_ready_allow,
  // PCI target gating
  output logic                          pci_claim_allow,
  output logic                          pci_force_retry,
  output logic                          pci_no_claim,
  // loaded registers
  output logic                          cfg_wr_valid,
  output boot_loader_pkg::cfg_write_t   cfg_wr,
  // software access port
  input  wire logic                     sw_req_valid,
  input  wire boot_loader_pkg::sw_req_t sw_req,
  output logic                          sw_ready,
  output logic                          sw_done,
  output logic [31:0]                   sw_rdata,
  // status
  output logic                          serial_mem_present,
  output logic                          local_init_status,
  output logic                          load_done
);
  import boot_loader_pkg::*;

  typedef enum logic [3:0] {
    S_CATCH, S_BOOT_GO, S_BOOT_RUN, S_IDLE, S_RD_GO, S_RD_RUN,
    S_EWEN_GO, S_EWEN_RUN, S_WR_GO, S_WR_RUN, S_BUSY_GO, S_BUSY_RUN
  } state_t;

  // builds a frame: start bit, opcode, address, data, left aligned
  function automatic frame_t make_frame(input logic [1:0] op,
                                        input logic [MEM_ADDR_W-1:0] addr,
                                        input logic [WORD_W-1:0] data,
                                        input logic [OCNT_W-1:0] ocnt,
                                        input logic [ICNT_W-1:0] icnt);
    frame_t f;
    f.sr   = {1'b1, op, addr, data};
    f.ocnt = ocnt;
    f.icnt = icnt;
    return f;
  endfunction : make_frame

  localparam logic [OCNT_W-1:0] CMD_CNT  = OCNT_W'(CMD_W);
  localparam logic [OCNT_W-1:0] FULL_CNT = OCNT_W'(OUT_W);
  localparam logic [ICNT_W-1:0] RD32_CNT = ICNT_W'(1 + 2 * WORD_W);
  localparam logic [ICNT_W-1:0] LONG_CNT = ICNT_W'(1 + LONG_WORDS * WORD_W);
  localparam logic [ICNT_W-1:0] XLNG_CNT = ICNT_W'(1 + XLONG_WORDS * WORD_W);
  localparam logic [DIV_W-1:0]  DIV_LAST = DIV_W'(SK_DIV - 1);
  localparam logic [DIV_W-1:0]  DIV_HALF = DIV_W'(SK_HALF);
  localparam logic [DIV_W-1:0]  DIV_REL  = DIV_W'(SK_HALF + 1);  // first edge after the clock rise
  localparam logic [5:0]        INIT_IDX = 6'(INIT_WORD);

  logic                   rst_s1_r, rst_s2_r;
  logic                   user_s1_r, user_s2_r, din_s1_r, din_s2_r;
  logic [DIV_W-1:0]       div_r;
  logic                   sk_r;
  state_t                 state_r, state_nxt;
  logic                   cs_r, cs_nxt, oe_r, oe_nxt;
  logic [OUT_W-1:0]       osr_r, osr_nxt;
  logic [OCNT_W-1:0]      ocnt_r, ocnt_nxt;
  logic [ICNT_W-1:0]      icnt_r, icnt_nxt;
  logic                   dummy_r, dummy_nxt;
  logic [3:0]             bit_r, bit_nxt;
  logic [WORD_W-2:0]      isr_r, isr_nxt;
  logic [5:0]             widx_r, widx_nxt;
  logic [WORD_W-1:0]      hi_r, hi_nxt;
  logic                   present_r, present_nxt;
  logic                   init_r, init_nxt;
  logic                   retry_r, retry_nxt;
  logic                   cfgv_r, cfgv_nxt;
  cfg_write_t             cfg_r, cfg_nxt;
  logic                   done_r, done_nxt;
  logic [31:0]            rdata_r, rdata_nxt;
  sw_req_t                req_r, req_nxt;
  logic                   half_r, half_nxt;
  logic                   go;
  frame_t                 fr;

  // decoded engine events
  wire                    rst_q_n   = rst_s2_r;
  wire                    tick      = (div_r == DIV_LAST);
  wire                    cap       = cs_r && (ocnt_r <= OCNT_W'(1)) && (icnt_r != '0);
  wire                    word_done = cap && !dummy_r && (bit_r == 4'hf);
  wire [WORD_W-1:0]       word      = {isr_r, din_s2_r};
  wire                    last_word = (icnt_r == ICNT_W'(1));
  wire                    xlong     = space0_bus_region_desc[XLONG_BIT];
  wire [MEM_ADDR_W-1:0]   wr_addr   = req_r.addr + MEM_ADDR_W'(half_r);
  wire [WORD_W-1:0]       wr_data   = half_r ? req_r.wdata[15:0] : req_r.wdata[31:16];
  wire                    booting   = (state_r == S_CATCH) || (state_r == S_BOOT_GO)
                                      || (state_r == S_BOOT_RUN);

  // reset release through two flip-flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end

  // pin synchronisers run through reset so the level is valid at release
  always_ff @(posedge core_clk) begin
    user_s1_r <= user_input_pin;
    user_s2_r <= user_s1_r;
    din_s1_r  <= serial_mem_data_pin_i;
    din_s2_r  <= din_s1_r;
  end

  // serial clock divider, one frame bit per divided period
  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      div_r <= '0;
      sk_r  <= 1'b0;
    end else begin
      div_r <= tick ? '0 : div_r + DIV_W'(1);
      sk_r  <= cs_r && !tick && (div_r >= DIV_HALF);  // falls with select
    end
  end

  // shift engine and sequencer next state
  always_comb begin
    state_nxt   = state_r;
    cs_nxt      = cs_r;
    oe_nxt      = oe_r;
    osr_nxt     = osr_r;
    ocnt_nxt    = ocnt_r;
    icnt_nxt    = icnt_r;
    dummy_nxt   = dummy_r;
    bit_nxt     = bit_r;
    isr_nxt     = isr_r;
    widx_nxt    = widx_r;
    hi_nxt      = hi_r;
    present_nxt = present_r;
    init_nxt    = init_r | local_init_set;
    retry_nxt   = retry_r;
    cfgv_nxt    = 1'b0;
    cfg_nxt     = cfg_r;
    done_nxt    = 1'b0;
    rdata_nxt   = rdata_r;
    req_nxt     = req_r;
    half_nxt    = half_r;
    go          = 1'b0;
    fr          = '0;
    // hand the pin back once the memory has sampled our last bit, so the dummy bit is seen
    if (cs_r && oe_r && ocnt_r == OCNT_W'(1) && div_r == DIV_REL) begin
      oe_nxt = 1'b0;
    end
    if (state_r == S_CATCH) begin
      retry_nxt = user_s2_r;
      state_nxt = S_BOOT_GO;
    end else if (state_r == S_IDLE && sw_req_valid) begin
      req_nxt   = sw_req;
      half_nxt  = 1'b0;
      state_nxt = sw_req.write ? S_EWEN_GO : S_RD_GO;
    end
    if (tick) begin
      // output side: next bit MSB first, release the pin after the last one
      if (cs_r && ocnt_r != '0) begin
        osr_nxt  = osr_r << 1;
        ocnt_nxt = ocnt_r - OCNT_W'(1);
        if (ocnt_r == OCNT_W'(1)) begin
          oe_nxt = 1'b0;
        end
      end
      // input side: dummy bit, then 16-bit words MSB first
      if (cap) begin
        icnt_nxt = icnt_r - ICNT_W'(1);
        if (dummy_r) begin
          dummy_nxt = 1'b0;
        end else begin
          isr_nxt = word[WORD_W-2:0];
          bit_nxt = bit_r + 4'h1;
        end
      end
      case (state_r)
        S_BOOT_GO: begin
          go        = 1'b1;
          fr        = make_frame(OP_READ, '0, '0, CMD_CNT, xlong ? XLNG_CNT : LONG_CNT);
          widx_nxt  = '0;
          state_nxt = S_BOOT_RUN;
        end
        S_BOOT_RUN: begin
          if (cap && dummy_r && din_s2_r) begin
            cs_nxt    = 1'b0;  // no zero bit: nothing attached
            init_nxt  = 1'b1;
            state_nxt = S_IDLE;
          end else if (word_done) begin
            widx_nxt = widx_r + 6'h1;
            hi_nxt   = word;  // upper word arrives first
            if (widx_r == '0 && (word == BLANK_WORD || word == ABSENT_WORD)) begin
              present_nxt = (word == BLANK_WORD);
              init_nxt    = 1'b1;
              cs_nxt      = 1'b0;
              state_nxt   = S_IDLE;
            end else begin
              present_nxt = 1'b1;
              if (widx_r[0]) begin
                cfgv_nxt = 1'b1;
                cfg_nxt  = '{index: widx_r[5:1], data: {hi_r, word}};
              end
              if (widx_r == INIT_IDX && word[INIT_WBIT]) begin
                init_nxt = 1'b1;
              end
              if (last_word) begin
                cs_nxt    = 1'b0;
                state_nxt = S_IDLE;
              end
            end
          end
        end
        S_RD_GO: begin
          go        = 1'b1;
          fr        = make_frame(OP_READ, req_r.addr, '0, CMD_CNT, RD32_CNT);
          state_nxt = S_RD_RUN;
        end
        S_RD_RUN: begin
          if (word_done && last_word) begin
            rdata_nxt[15:0] = word;
            done_nxt        = 1'b1;
            cs_nxt          = 1'b0;
            state_nxt       = S_IDLE;
          end else if (word_done) begin
            rdata_nxt[31:16] = word;
          end
        end
        S_EWEN_GO: begin
          go        = 1'b1;
          fr        = make_frame(OP_EWEN, EWEN_ADDR, '0, CMD_CNT, '0);
          state_nxt = S_EWEN_RUN;
        end
        S_WR_GO: begin
          go        = 1'b1;
          fr        = make_frame(OP_WRITE, wr_addr, wr_data, FULL_CNT, '0);
          state_nxt = S_WR_RUN;
        end
        S_EWEN_RUN, S_WR_RUN: begin
          if (ocnt_r == '0) begin
            cs_nxt    = 1'b0;
            state_nxt = (state_r == S_EWEN_RUN) ? S_WR_GO : S_BUSY_GO;
          end
        end
        S_BUSY_GO: begin
          go        = 1'b1;  // select only, then poll for ready
          state_nxt = S_BUSY_RUN;
        end
        S_BUSY_RUN: begin
          if (din_s2_r) begin
            cs_nxt    = 1'b0;
            half_nxt  = 1'b1;
            done_nxt  = half_r;
            state_nxt = half_r ? S_IDLE : S_WR_GO;
          end
        end
        default: begin
          state_nxt = state_r;
        end
      endcase
      if (go) begin
        cs_nxt    = 1'b1;
        oe_nxt    = (fr.ocnt != '0);
        osr_nxt   = fr.sr;
        ocnt_nxt  = fr.ocnt;
        icnt_nxt  = fr.icnt;
        dummy_nxt = 1'b1;
        bit_nxt   = '0;
      end
    end
  end

  // sequencer and engine registers
  always_ff @(posedge core_clk or negedge rst_q_n) begin
    if (!rst_q_n) begin
      state_r <= S_CATCH;
      {cs_r, oe_r, osr_r, ocnt_r, icnt_r, dummy_r, bit_r, isr_r} <= '0;
      {widx_r, hi_r, present_r, init_r, retry_r} <= '0;
      {cfgv_r, cfg_r, done_r, rdata_r, req_r, half_r} <= '0;
    end else begin
      state_r <= state_nxt;
      {cs_r, oe_r, osr_r, ocnt_r, icnt_r} <= {cs_nxt, oe_nxt, osr_nxt, ocnt_nxt, icnt_nxt};
      {dummy_r, bit_r, isr_r, widx_r, hi_r} <= {dummy_nxt, bit_nxt, isr_nxt, widx_nxt, hi_nxt};
      {present_r, init_r, retry_r} <= {present_nxt, init_nxt, retry_nxt};
      {cfgv_r, cfg_r, done_r, rdata_r} <= {cfgv_nxt, cfg_nxt, done_nxt, rdata_nxt};
      {req_r, half_r} <= {req_nxt, half_nxt};
    end
  end

  // pins and status
  assign serial_mem_clock       = sk_r;
  assign serial_mem_select      = cs_r;
  assign serial_mem_data_pin_o  = osr_r[OUT_W-1];
  assign serial_mem_data_pin_oe = oe_r;
  assign user_input_level       = user_s2_r;
  assign pci_retry_mode         = retry_r;
  assign local_ready_allow      = !booting;
  assign pci_claim_allow        = init_r;
  assign pci_force_retry        = !init_r && retry_r;
  assign pci_no_claim           = !init_r && !retry_r;
  assign cfg_wr_valid           = cfgv_r;
  assign cfg_wr                 = cfg_r;
  assign sw_ready               = (state_r == S_IDLE);
  assign sw_done                = done_r;
  assign sw_rdata               = rdata_r;
  assign serial_mem_present     = present_r;
  assign local_init_status      = init_r;
  assign load_done              = !booting;
endmodule : serial_eeprom_boot_loader

// file: sim/boot_loader_chk.sv
// port assertions for the serial memory boot loader
`timescale 1ns/1ps
module boot_loader_chk (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // serial memory pins
  input wire logic serial_mem_clock,
  input wire logic serial_mem_select,
  input wire logic serial_mem_data_pin_o,
  input wire logic serial_mem_data_pin_oe,
  // gating and status
  input wire logic pci_retry_mode,
  input wire logic local_ready_allow,
  input wire logic pci_claim_allow,
  input wire logic pci_force_retry,
  input wire logic pci_no_claim,
  input wire logic serial_mem_present,
  input wire logic local_init_status,
  input wire logic load_done,
  // load and software port
  input wire logic cfg_wr_valid,
  input wire logic sw_req_valid,
  input wire logic sw_ready,
  input wire logic sw_done
);
  logic [8:0] gap_r;
  logic       run_r;
  logic       sk_d_r;

  // cycles since the last serial clock rise, valid while one frame runs on
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      gap_r  <= 9'h000;
      run_r  <= 1'b0;
      sk_d_r <= 1'b0;
    end else begin
      sk_d_r <= serial_mem_clock;
      gap_r  <= (serial_mem_clock && !sk_d_r) ? 9'h000 : gap_r + 9'h001;
      run_r  <= serial_mem_select && (run_r || (serial_mem_clock && !sk_d_r));
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // steps of the software access and of the absent-memory finish
  sequence s_take;
    sw_ready && sw_req_valid;
  endsequence
  sequence s_absent_end;
    $rose(load_done) && !serial_mem_present;
  endsequence

  a_claim_init: assert property (!local_init_status |-> !pci_claim_allow)
    else $error("claim allowed before init");
  a_retry_gate: assert property (pci_force_retry |-> pci_retry_mode && !local_init_status)
    else $error("retry outside retry mode");
  a_noclaim_gate: assert property (pci_no_claim |-> !pci_retry_mode && !local_init_status)
    else $error("no claim outside quiet mode");
  a_init_open: assert property (local_init_status |-> pci_claim_allow && !pci_force_retry)
    else $error("gating held after init");
  a_ready_stall: assert property (!load_done |-> !local_ready_allow)
    else $error("local ready during load");
  a_done_stays: assert property (load_done |=> load_done)
    else $error("done state left");
  a_absent_init: assert property (s_absent_end |-> ##[0:2] local_init_status)
    else $error("init not set for absent memory");
  a_cfg_pulse: assert property (cfg_wr_valid |-> !$past(load_done) ##1 !cfg_wr_valid)
    else $error("bad register load pulse");
  a_sk_select: assert property (serial_mem_clock |-> serial_mem_select)
    else $error("serial clock outside a frame");
  a_sk_period: assert property ($rose(serial_mem_clock) && run_r |-> gap_r == 9'h10b)
    else $error("serial clock period wrong");
  a_start_bit: assert property ($rose(serial_mem_select) |-> serial_mem_data_pin_oe && serial_mem_data_pin_o)
    else $error("frame not opened by a start bit");
  a_sw_busy: assert property (s_take |=> !sw_ready ##1 !sw_done)
    else $error("software port not busy after request");
endmodule : boot_loader_chk

bind serial_eeprom_boot_loader boot_loader_chk chk_i (.*);

// file: sim/serial_mem_model.sv
// behavioural serial configuration memory, sequential read
`timescale 1ns/1ps
module serial_mem_model (
  // serial pins
  input  wire logic sk,
  input  wire logic cs,
  input  wire logic di,
  // board fitting
  input  wire logic attached,
  // data drive
  output logic      dout,
  output logic      dout_en
);
  logic [15:0] mem [256];
  logic [10:0] cmd;
  logic [7:0]  addr;
  int          cnt;
  int          bitn;

  initial begin
    dout    = 1'b0;
    dout_en = 1'b0;
  end

  // shift in the command, then stream words on each clock rise
  always @(posedge sk or negedge cs) begin
    if (!cs) begin
      cnt     = 0;
      dout_en = 1'b0; // line released to the board pull
    end else if (cnt < 11) begin
      cmd = {cmd[9:0], di};
      cnt = cnt + 1;
      if (cnt == 11 && cmd[10:8] == 3'h6 && attached) begin
        addr    = cmd[7:0];
        bitn    = 0;
        dout    = 1'b0; // leading dummy zero
        dout_en = 1'b1;
      end
    end else if (dout_en) begin
      dout = mem[addr][15 - bitn];
      bitn = bitn + 1;
      if (bitn == 16) begin
        bitn = 0;
        addr = addr + 8'h01; // words stored back to back
      end
    end
  end
endmodule : serial_mem_model

// file: sim/serial_eeprom_boot_loader_test.sv
// self-checking bench for the serial memory boot loader
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin error_cnt++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module serial_eeprom_boot_loader_test;
  import boot_loader_pkg::*;
  logic        core_clk, reset_n, sk, cs, pin_i, d_o, d_oe, m_do, m_en, upin, lvl, rmode;
  logic        lis, lrdy, claim, fretry, nclaim, cfg_v, sreq_v, sw_rdy, sw_dn;
  logic        present, init, done, attached, pull_lvl;
  logic [31:0] desc, rdata, exp_w;
  logic [31:0] exp_q[$];
  cfg_write_t  cfg;
  sw_req_t     sreq;
  logic [7:0]  a;
  int          error_cnt, num_checks, n_cfg, want;

  // device drive first, then the memory, else the board pull
  assign pin_i = d_oe ? d_o : (m_en ? m_do : pull_lvl);
  always #25 core_clk = ~core_clk;

  serial_eeprom_boot_loader dut (.core_clk(core_clk), .reset_n(reset_n),
    .serial_mem_clock(sk), .serial_mem_select(cs), .serial_mem_data_pin_i(pin_i),
    .serial_mem_data_pin_o(d_o), .serial_mem_data_pin_oe(d_oe), .user_input_pin(upin),
    .user_input_level(lvl), .pci_retry_mode(rmode), .space0_bus_region_desc(desc),
    .local_init_set(lis), .local_ready_allow(lrdy), .pci_claim_allow(claim),
    .pci_force_retry(fretry), .pci_no_claim(nclaim), .cfg_wr_valid(cfg_v), .cfg_wr(cfg),
    .sw_req_valid(sreq_v), .sw_req(sreq), .sw_ready(sw_rdy), .sw_done(sw_dn),
    .sw_rdata(rdata), .serial_mem_present(present), .local_init_status(init),
    .load_done(done));
  serial_mem_model mem_i (.sk(sk), .cs(cs), .di(pin_i), .attached(attached),
    .dout(m_do), .dout_en(m_en));

  // each loaded register against the reference queue
  always @(posedge core_clk) begin
    if (cfg_v === 1'b1) begin
      exp_w = exp_q.size() > 0 ? exp_q.pop_front() : 32'h0;
      `CHK("cfg index", 5'(n_cfg), cfg.index);
      `CHK("cfg data", exp_w, cfg.data);
      n_cfg++;
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // 0: load finished, 1: software done, 2: enough registers loaded
  task automatic wait_for(input int sel, input int lim);
    int n;
    n = 0;
    while (!(sel == 0 ? done === 1'b1 : sel == 1 ? sw_dn === 1'b1 : n_cfg >= want)
           && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= lim) begin
      error_cnt++;
      $display("unexpected timeout on wait %0d", sel);
      conclude();
    end
  endtask : wait_for

  task automatic boot(input logic up, input logic att, input logic pl);
    @(posedge core_clk);
    #1 reset_n = 1'b0;
    upin = up;
    attached = att;
    pull_lvl = pl;
    n_cfg = 0;
    exp_q.delete();
    repeat (20) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
  endtask : boot

  initial begin
    core_clk = 1'b0;
    reset_n = 1'b0;
    {upin, lis, sreq_v, attached, pull_lvl} = 5'h00;
    sreq = '0;
    desc = 32'h0;
    void'($urandom(32'hef549fbe));
    // no memory fitted: line pulled low, then pulled high
    for (int p = 0; p < 2; p++) begin
      boot(1'b0, 1'b0, p[0]);
      `CHK("no claim", 1'b1, nclaim);
      `CHK("local ready", 1'b0, lrdy);
      wait_for(0, 20000);
      #1 upin = 1'b1;
      `CHK("present", 1'b0, present);
      `CHK("init", 1'b1, init);
      `CHK("claim", 1'b1, claim);
      `CHK("ready after", 1'b1, lrdy);
      repeat (4) @(posedge core_clk);
      #1;
      `CHK("gp input", 1'b1, lvl);
      `CHK("mode kept", 1'b0, rmode);
      `CHK("loads", 0, n_cfg);
    end
    // blank memory, retry mode, then a software read
    for (int i = 0; i < 256; i++) mem_i.mem[i] = 16'($urandom);
    mem_i.mem[0] = 16'hffff;
    desc = $urandom;
    boot(1'b1, 1'b1, 1'b1);
    `CHK("retry", 1'b1, fretry);
    wait_for(0, 20000);
    #1;
    `CHK("present", 1'b1, present);
    `CHK("init", 1'b1, init);
    `CHK("loads", 0, n_cfg);
    `CHK("sw ready", 1'b1, sw_rdy);
    a = 8'($urandom);
    sreq = '{write: 1'b0, addr: a, wdata: $urandom};
    sreq_v = 1'b1;
    @(posedge core_clk);
    #1 sreq_v = 1'b0;
    wait_for(1, 20000);
    #1;
    `CHK("sw rdata", {mem_i.mem[a], mem_i.mem[8'(a + 8'h01)]}, rdata);
    // programmed image: first registers, reset mid-load, then processor init
    mem_i.mem[0] = (16'($urandom) & 16'h7fff) | 16'h0001;
    desc = 32'h0; // extra-long-load bit left at zero
    for (int r = 0; r < 2; r++) begin
      want = 3 - 2 * r;
      boot(1'b1, 1'b1, 1'b1);
      `CHK("init clear", 1'b0, init);
      `CHK("done clear", 1'b0, done);
      for (int i = 0; i < want; i++) exp_q.push_back({mem_i.mem[2*i], mem_i.mem[2*i+1]});
      wait_for(2, 40000);
      #1;
      `CHK("retry", 1'b1, fretry);
      `CHK("stall", 1'b0, lrdy);
    end
    lis = 1'b1;
    @(posedge core_clk);
    #1 lis = 1'b0;
    `CHK("init set", 1'b1, init);
    `CHK("claim", 1'b1, claim);
    `CHK("retry off", 1'b0, fretry);
    conclude();
  end
endmodule : serial_eeprom_boot_loader_test
